// *** rtl/opaddr_pkg.sv ***
// Package of constants and carriers for operand address generation
// ==========================================================================
// Behaviour
// - Register jump loads accumulator pair into counter
// - Direct mode uses 16-bit immediate unchanged
// - Short direct reaches only FE80H..FF1FH window
// - Bit 8 clear for 80H-FFH, set 00H-1FH
// - Word short direct accepts even addresses only
// - Special register address is FF00H plus field
// - FF00H..FF1FH special registers use short path
// - Three-bit field selects one byte register
// - Bytes indexed 0..7, pairs 0..3 adjacent
// - Indirect uses one of two pointer pairs
// - Based adds zero-extended offset, drops carry
// - Stack pointer addresses push, pop, call, return
// - Stack accesses stay inside internal high RAM
// - Counter increments per byte, loads on branch
`default_nettype none
package opaddr_pkg;
   // ==========================================================================
   // Address map
   localparam logic [15:0] SHORT_LOW = 16'hFE80;
   localparam logic [15:0] SHORT_HIGH = 16'hFF1F;
   localparam logic [15:0] STACK_LOW = 16'hFE80;
   localparam logic [15:0] STACK_HIGH = 16'hFEFF;
   localparam logic [7:0] SPECIAL_PAGE = 8'hFF;
   localparam logic [7:0] SHORT_SPECIAL_TOP = 8'h1F;
   localparam logic [7:0] SHORT_RAM_BASE = 8'h80;
   localparam logic [6:0] SHORT_HIGH_BITS = 7'h7F;
   localparam int SHORT_BIT8_POS = 8;
   // ==========================================================================
   // Reset values
   localparam logic [15:0] COUNTER_RESET = 16'h0000;
   localparam logic [15:0] STACK_RESET = 16'hFF00;
   localparam logic [7:0] BYTE_REG_RESET = 8'h00;
   // ==========================================================================
   // Register indices
   localparam logic [2:0] IDX_ACC_LOW = 3'h0;
   localparam logic [1:0] PAIR_ACC = 2'h0;
   localparam logic [1:0] PAIR_PTR_ONE = 2'h2;
   localparam logic [1:0] PAIR_BASE = 2'h3;
   // ==========================================================================
   // Operations
   typedef enum logic [3:0] {
      MODE_NONE = 4'h0, MODE_DIRECT = 4'h1, MODE_SHORT = 4'h2, MODE_SHORT_WORD = 4'h3,
      MODE_SPECIAL = 4'h4, MODE_INDIRECT = 4'h5, MODE_BASED = 4'h6
   } mode_type;
   typedef enum logic [2:0] {
      STK_NONE = 3'h0, STK_PUSH = 3'h1, STK_POP = 3'h2, STK_CALL = 3'h3,
      STK_RETURN = 3'h4, STK_IRQ_SAVE = 3'h5, STK_IRQ_RESTORE = 3'h6
   } stack_op_type;
   typedef enum logic [1:0] {
      PC_HOLD = 2'h0, PC_FETCH = 2'h1, PC_REG_JUMP = 2'h2, PC_LOAD = 2'h3
   } pc_op_type;

   // Request from the instruction decoder
   typedef struct packed {
      logic valid;
      mode_type mode;
      logic [15:0] full_direct_operand;
      logic [7:0] field;
      logic indirect_sel_base;
      pc_op_type pc_op;
      logic [15:0] branch_target;
      stack_op_type stack_op;
      logic sp_load;
      logic [15:0] sp_value;
   } decode_req_type;

   // Register-file write port
   typedef struct packed {
      logic byte_we;
      logic [2:0] byte_sel;
      logic [7:0] byte_data;
      logic pair_we;
      logic [1:0] register_pair_selector;
      logic [15:0] pair_data;
   } reg_write_type;

   // Memory address answer
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic fault;
      logic stack;
   } mem_addr_type;
endpackage
`default_nettype wire

// *** rtl/opaddr_regfile.sv ***
// General-purpose byte registers with pair view
`default_nettype none
module opaddr_regfile
   import opaddr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire reg_write_type wr_i,
   input wire logic [2:0] byte_sel_i,
   input wire logic [1:0] pair_sel_a_i,
   input wire logic [1:0] pair_sel_b_i,
   output logic [7:0] byte_o,
   output logic [15:0] pair_a_o,
   output logic [15:0] pair_b_o
);
   typedef struct packed {
      logic [7:0][7:0] regs;
   } rf_state_type;

   rf_state_type state_r;
   rf_state_type state_nxt;

   // Pair p is byte 2p+1 (high) over byte 2p (low)
   function automatic logic [15:0] pair_of(input rf_state_type s, input logic [1:0] p);
      pair_of = {s.regs[{p, 1'b1}], s.regs[{p, 1'b0}]};
   endfunction

   always_comb begin
      state_nxt = state_r;
      if (wr_i.pair_we) begin
         state_nxt.regs[{wr_i.register_pair_selector, 1'b1}] = wr_i.pair_data[15:8];
         state_nxt.regs[{wr_i.register_pair_selector, 1'b0}] = wr_i.pair_data[7:0];
      end
      if (wr_i.byte_we) begin
         state_nxt.regs[wr_i.byte_sel] = wr_i.byte_data;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= '{regs: {8{BYTE_REG_RESET}}};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign byte_o = state_r.regs[byte_sel_i];
   assign pair_a_o = pair_of(state_r, pair_sel_a_i);
   assign pair_b_o = pair_of(state_r, pair_sel_b_i);
endmodule
`default_nettype wire

// *** rtl/opaddr_stack.sv ***
// Stack pointer with automatic pre-decrement and post-increment
`default_nettype none
module opaddr_stack
   import opaddr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire stack_op_type op_i,
   input wire logic load_i,
   input wire logic [15:0] load_value_i,
   output logic [15:0] stack_pointer_o,
   output logic [15:0] addr_o,
   output logic active_o,
   output logic fault_o
);
   typedef struct packed {
      logic [15:0] stack_pointer;
   } sp_state_type;

   sp_state_type state_r;
   sp_state_type state_nxt;
   logic push_like;
   logic pop_like;

   always_comb begin
      push_like = (op_i == STK_PUSH) || (op_i == STK_CALL) || (op_i == STK_IRQ_SAVE);
      pop_like = (op_i == STK_POP) || (op_i == STK_RETURN) || (op_i == STK_IRQ_RESTORE);
      state_nxt = state_r;
      addr_o = state_r.stack_pointer;
      if (push_like) begin
         // Push writes below the current top
         addr_o = state_r.stack_pointer - 16'h0001;
         state_nxt.stack_pointer = addr_o;
      end else if (pop_like) begin
         state_nxt.stack_pointer = state_r.stack_pointer + 16'h0001;
      end else if (load_i) begin
         state_nxt.stack_pointer = load_value_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= '{stack_pointer: STACK_RESET};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign active_o = push_like || pop_like;
   // Flagged, not suppressed: the access itself is refused by the top
   assign fault_o = active_o && ((addr_o < STACK_LOW) || (addr_o > STACK_HIGH));
   assign stack_pointer_o = state_r.stack_pointer;
endmodule
`default_nettype wire

// *** rtl/operand_address_generation.sv ***
// Operand and instruction address generation for the 8-bit core
`default_nettype none
module operand_address_generation
   import opaddr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire decode_req_type req_i,
   input wire reg_write_type reg_wr_i,
   input wire logic [2:0] byte_sel_i,
   output logic [7:0] byte_operand_o,
   output mem_addr_type mem_o,
   output logic [15:0] program_counter_o,
   output logic [15:0] stack_pointer_o
);
   // ==========================================================================
   // State
   typedef struct packed {
      logic [15:0] program_counter;
      mem_addr_type mem;
      logic [7:0] byte_operand;
   } top_state_type;

   top_state_type state_r;
   top_state_type state_nxt;

   logic [15:0] acc_pair;
   logic [15:0] ptr_pair;
   logic [7:0] byte_value;
   logic [15:0] sp_addr;
   logic sp_active;
   logic sp_fault;
   logic [1:0] ptr_sel;

   // ==========================================================================
   // Address functions
   function automatic logic [15:0] short_addr(input logic [7:0] f);
      logic bit8;
      bit8 = (f <= SHORT_SPECIAL_TOP);
      short_addr = {SHORT_HIGH_BITS, bit8, f};
   endfunction

   // Field values 20H..7FH fall outside the window and are refused
   function automatic logic short_legal(input logic [7:0] f);
      short_legal = (f >= SHORT_RAM_BASE) || (f <= SHORT_SPECIAL_TOP);
   endfunction

   assign ptr_sel = req_i.indirect_sel_base ? PAIR_BASE : PAIR_PTR_ONE;

   opaddr_regfile u_regfile (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_i(reg_wr_i),
      .byte_sel_i(byte_sel_i),
      .pair_sel_a_i(PAIR_ACC),
      .pair_sel_b_i(ptr_sel),
      .byte_o(byte_value),
      .pair_a_o(acc_pair),
      .pair_b_o(ptr_pair)
   );

   opaddr_stack u_stack (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .op_i(req_i.valid ? req_i.stack_op : STK_NONE),
      .load_i(req_i.valid && req_i.sp_load),
      .load_value_i(req_i.sp_value),
      .stack_pointer_o(stack_pointer_o),
      .addr_o(sp_addr),
      .active_o(sp_active),
      .fault_o(sp_fault)
   );

   // ==========================================================================
   // Next state
   always_comb begin
      state_nxt = state_r;
      state_nxt.mem = '0;
      state_nxt.byte_operand = byte_value;
      if (req_i.valid) begin
         case (req_i.pc_op)
            PC_FETCH: state_nxt.program_counter = state_r.program_counter + 16'h0001;
            PC_REG_JUMP: state_nxt.program_counter = acc_pair;
            PC_LOAD: state_nxt.program_counter = req_i.branch_target;
            default: state_nxt.program_counter = state_r.program_counter;
         endcase
         if (sp_active) begin
            state_nxt.mem.valid = !sp_fault;
            state_nxt.mem.addr = sp_addr;
            state_nxt.mem.fault = sp_fault;
            state_nxt.mem.stack = 1'b1;
         end else begin
            case (req_i.mode)
               MODE_DIRECT: begin
                  state_nxt.mem.valid = 1'b1;
                  state_nxt.mem.addr = req_i.full_direct_operand;
               end
               MODE_SHORT: begin
                  state_nxt.mem.addr = short_addr(req_i.field);
                  state_nxt.mem.valid = short_legal(req_i.field);
                  state_nxt.mem.fault = !short_legal(req_i.field);
               end
               MODE_SHORT_WORD: begin
                  state_nxt.mem.addr = short_addr(req_i.field);
                  // Odd word address rejected rather than silently aligned
                  state_nxt.mem.valid = short_legal(req_i.field) && !req_i.field[0];
                  state_nxt.mem.fault = !(short_legal(req_i.field) && !req_i.field[0]);
               end
               MODE_SPECIAL: begin
                  state_nxt.mem.addr = {SPECIAL_PAGE, req_i.field};
                  // Low 32 special registers belong to the short path
                  state_nxt.mem.valid = req_i.field > SHORT_SPECIAL_TOP;
                  state_nxt.mem.fault = req_i.field <= SHORT_SPECIAL_TOP;
               end
               MODE_INDIRECT: begin
                  state_nxt.mem.valid = 1'b1;
                  state_nxt.mem.addr = ptr_pair;
               end
               MODE_BASED: begin
                  state_nxt.mem.valid = 1'b1;
                  state_nxt.mem.addr = 16'(ptr_pair + {8'h00, req_i.field});
               end
               default: state_nxt.mem = '0;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= '{program_counter: COUNTER_RESET, mem: '0, byte_operand: BYTE_REG_RESET};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign mem_o = state_r.mem;
   assign program_counter_o = state_r.program_counter;
   assign byte_operand_o = state_r.byte_operand;
endmodule
`default_nettype wire

// *** verification/opaddr_decoder_model.sv ***
// Decoder side model: drives requests and register writes
`default_nettype none
module opaddr_decoder_model import opaddr_pkg::*; (
   input wire logic sys_clk_i,
   output var decode_req_type req_o,
   output var reg_write_type wr_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      req_o = '0;
      wr_o = '0;
   end
   // ==========
   // Requests change only at the falling edge; last drops valid after the taking edge
   task automatic send(input decode_req_type r, input logic last);
      r.valid = 1'b1;
      @(negedge sys_clk_i);
      req_o = r;
      if (last) begin
         @(negedge sys_clk_i);
         req_o = '0;
      end else
         @(posedge sys_clk_i);
   endtask
   task automatic put_wr(input reg_write_type w);
      @(negedge sys_clk_i);
      wr_o = w;
      @(negedge sys_clk_i);
      wr_o = '0;
   endtask
endmodule
`default_nettype wire

// *** verification/opaddr_checker.sv ***
// Port-level assertions for operand address generation
`default_nettype none
module opaddr_checker import opaddr_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire decode_req_type req_i,
   input wire reg_write_type reg_wr_i,
   input wire logic [2:0] byte_sel_i,
   input wire logic [7:0] byte_operand_o,
   input wire mem_addr_type mem_o,
   input wire logic [15:0] program_counter_o,
   input wire logic [15:0] stack_pointer_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Only mode requests without a stack operation form operand addresses
   logic act;
   logic [7:0] f;
   assign act = req_i.valid && req_i.stack_op == STK_NONE;
   assign f = req_i.field;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========
   // Assertions
   AST_DIRECT: assert property (
      act && req_i.mode == MODE_DIRECT |=> mem_o.valid && mem_o.addr == $past(req_i.full_direct_operand))
      else $error("direct address wrong");
   AST_SHORT_RAM: assert property (
      act && req_i.mode == MODE_SHORT && f >= 8'h80 |=> mem_o.valid && mem_o.addr == {7'h7F, 1'b0, $past(f)})
      else $error("short ram address wrong");
   AST_SHORT_SFR: assert property (
      act && req_i.mode == MODE_SHORT && f <= 8'h1F |=> mem_o.valid && mem_o.addr == {7'h7F, 1'b1, $past(f)})
      else $error("short register address wrong");
   AST_SHORT_GAP: assert property (
      act && req_i.mode == MODE_SHORT && f inside {[8'h20:8'h7F]} |=> !mem_o.valid && mem_o.fault)
      else $error("short gap not refused");
   AST_WORD_ODD: assert property (
      act && req_i.mode == MODE_SHORT_WORD && f[0] |=> !mem_o.valid && mem_o.fault)
      else $error("odd word not refused");
   AST_SPECIAL: assert property (
      act && req_i.mode == MODE_SPECIAL && f > 8'h1F |=> mem_o.valid && mem_o.addr == {8'hFF, $past(f)})
      else $error("special address wrong");
   AST_FETCH: assert property (
      req_i.valid && req_i.pc_op == PC_FETCH |=> program_counter_o == $past(program_counter_o) + 16'h1)
      else $error("fetch step wrong");
   AST_STACK_WIN: assert property (
      mem_o.valid && mem_o.stack |-> mem_o.addr inside {[16'hFE80:16'hFEFF]})
      else $error("stack access outside ram");
   AST_PUSH: assert property (
      req_i.valid && req_i.stack_op == STK_PUSH && stack_pointer_o inside {[16'hFE81:16'hFF00]}
      |=> stack_pointer_o == $past(stack_pointer_o) - 16'h1 && mem_o.stack && mem_o.addr == stack_pointer_o)
      else $error("push wrong");
   COV_SHORT: cover property (act && req_i.mode == MODE_SHORT ##1 mem_o.valid);
   COV_PUSH: cover property (req_i.valid && req_i.stack_op == STK_PUSH);
   COV_JUMP: cover property (req_i.valid && req_i.pc_op == PC_REG_JUMP);
endmodule
bind operand_address_generation opaddr_checker chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i),
   .reg_wr_i(reg_wr_i), .byte_sel_i(byte_sel_i), .byte_operand_o(byte_operand_o), .mem_o(mem_o),
   .program_counter_o(program_counter_o), .stack_pointer_o(stack_pointer_o));
`default_nettype wire

// *** verification/operand_address_generation_tb_top.sv ***
// Self-checking bench for operand address generation
`default_nettype none
module operand_address_generation_tb_top import opaddr_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk;
   logic rst;
   logic [2:0] bsel;
   logic [7:0] bop;
   logic [15:0] prog_cnt;
   logic [15:0] stk_ptr;
   decode_req_type req;
   reg_write_type wr;
   mem_addr_type mem;
   int failures;
   int num_checks;
   opaddr_decoder_model dec_u (.sys_clk_i(clk), .req_o(req), .wr_o(wr));
   operand_address_generation dut_u (.sys_clk_i(clk), .rst_i(rst), .req_i(req), .reg_wr_i(wr),
      .byte_sel_i(bsel), .byte_operand_o(bop), .mem_o(mem), .program_counter_o(prog_cnt), .stack_pointer_o(stk_ptr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========
   // Shared helpers
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic decode_req_type mk(input mode_type m, input logic [15:0] d, input logic s);
      decode_req_type r;
      r = '0;
      r.mode = m;
      r.full_direct_operand = d;
      r.field = d[7:0];
      r.indirect_sel_base = s;
      return r;
   endfunction
   task automatic q(input mode_type m, input logic [15:0] d, input logic s, input logic ok, input logic [15:0] ea);
      dec_u.send(mk(m, d, s), 1'b1);
      chk("valid", mem.valid, ok);
      chk("fault", mem.fault, !ok);
      chk("nostack", mem.stack, 1'b0);
      if (ok) chk("addr", mem.addr, ea);
   endtask
   task automatic st(input stack_op_type o, input logic [15:0] ea, input logic [15:0] es);
      decode_req_type r;
      // A direct mode rides along to show the stack operation wins
      r = mk(MODE_DIRECT, 16'h0001, 1'b0);
      r.stack_op = o;
      dec_u.send(r, 1'b1);
      chk("stack", {mem.valid, mem.stack}, 2'h3);
      chk("saddr", mem.addr, ea);
      chk("sptr", stk_ptr, es);
   endtask
   // ==========
   // Scenarios
   task automatic t_reset();
      chk("count", prog_cnt, 16'h0000);
      chk("sptr", stk_ptr, 16'hFF00);
      chk("mem", 16'({mem.valid, mem.fault, mem.stack}), 16'h0000);
      chk("maddr", mem.addr, 16'h0000);
      $display("t_reset done");
   endtask
   task automatic t_regs();
      logic [15:0] pv [4] = '{16'h3456, 16'h789A, 16'hFE90, 16'hFFF0};
      for (int p = 0; p < 4; p++)
         dec_u.put_wr('{pair_we: 1'b1, register_pair_selector: p[1:0], pair_data: pv[p], default: '0});
      for (int i = 0; i < 8; i++) begin
         @(negedge clk) bsel = i[2:0];
         @(negedge clk) chk("byte", bop, i[0] ? pv[i/2][15:8] : pv[i/2][7:0]);
      end
      dec_u.put_wr('{byte_we: 1'b1, byte_sel: 3'h3, byte_data: 8'h5A, default: '0});
      @(negedge clk) bsel = 3'h3;
      @(negedge clk) chk("byte", bop, 8'h5A);
      $display("t_regs done");
   endtask
   task automatic t_modes();
      q(MODE_DIRECT, 16'hFE80, 1'b0, 1'b1, 16'hFE80);
      q(MODE_DIRECT, 16'h0001, 1'b0, 1'b1, 16'h0001);
      q(MODE_SHORT, 16'h0000, 1'b0, 1'b1, 16'hFF00);
      q(MODE_SHORT, 16'h001F, 1'b0, 1'b1, 16'hFF1F);
      q(MODE_SHORT, 16'h0080, 1'b0, 1'b1, 16'hFE80);
      q(MODE_SHORT, 16'h00FF, 1'b0, 1'b1, 16'hFEFF);
      q(MODE_SHORT, 16'h0020, 1'b0, 1'b0, 16'h0000);
      q(MODE_SHORT, 16'h007F, 1'b0, 1'b0, 16'h0000);
      q(MODE_SHORT_WORD, 16'h001E, 1'b0, 1'b1, 16'hFF1E);
      q(MODE_SHORT_WORD, 16'h0081, 1'b0, 1'b0, 16'h0000);
      q(MODE_SPECIAL, 16'h0020, 1'b0, 1'b1, 16'hFF20);
      q(MODE_SPECIAL, 16'h00FF, 1'b0, 1'b1, 16'hFFFF);
      q(MODE_SPECIAL, 16'h001F, 1'b0, 1'b0, 16'h0000);
      q(MODE_INDIRECT, 16'h0000, 1'b0, 1'b1, 16'hFE90);
      q(MODE_INDIRECT, 16'h0000, 1'b1, 1'b1, 16'hFFF0);
      q(MODE_BASED, 16'h0020, 1'b1, 1'b1, 16'h0010);
      q(MODE_BASED, 16'h0005, 1'b1, 1'b1, 16'hFFF5);
      $display("t_modes done");
   endtask
   task automatic t_prog();
      decode_req_type r;
      r = mk(MODE_NONE, 16'h1234, 1'b0);
      r.pc_op = PC_FETCH;
      dec_u.send(r, 1'b0);
      dec_u.send(r, 1'b0);
      dec_u.send(r, 1'b1);
      chk("count", prog_cnt, 16'h0003);
      r.pc_op = PC_LOAD;
      r.branch_target = 16'h1234;
      dec_u.send(r, 1'b1);
      chk("count", prog_cnt, 16'h1234);
      r.pc_op = PC_REG_JUMP;
      dec_u.send(r, 1'b1);
      chk("count", prog_cnt, 16'h3456);
      $display("t_prog done");
   endtask
   task automatic t_stack();
      decode_req_type r;
      st(STK_PUSH, 16'hFEFF, 16'hFEFF);
      st(STK_CALL, 16'hFEFE, 16'hFEFE);
      st(STK_IRQ_SAVE, 16'hFEFD, 16'hFEFD);
      st(STK_POP, 16'hFEFD, 16'hFEFE);
      st(STK_RETURN, 16'hFEFE, 16'hFEFF);
      st(STK_IRQ_RESTORE, 16'hFEFF, 16'hFF00);
      r = mk(MODE_NONE, 16'h0000, 1'b0);
      r.sp_load = 1'b1;
      r.sp_value = 16'hFE80;
      dec_u.send(r, 1'b1);
      chk("sptr", stk_ptr, 16'hFE80);
      r.sp_load = 1'b0;
      r.stack_op = STK_PUSH;
      dec_u.send(r, 1'b1);
      chk("refuse", {mem.valid, mem.fault}, 2'h1);
      $display("t_stack done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========
   // Main sequence and watchdog
   initial begin
      rst = 1'b1;
      bsel = 3'h0;
      failures = 0;
      num_checks = 0;
      repeat (5) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      t_reset();
      t_regs();
      t_modes();
      t_prog();
      t_stack();
      tally_and_finish();
   end
   initial begin
      #50000;
      failures++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
